//--- rtl/iof_fault.sv
/*
 Input overvoltage fault detection and response sequencer with its two
 registers. Assumes the measurement, the exponent setting and the register
 strobes all come from logic on clk_sys.
*/
// Behaviour
// - Fault raised when measured input voltage exceeds the programmed limit.
// - Limit holds writable 11-bit mantissa; threshold is mantissa times 2^N.
// - Limit bits 15:11 read back exponent N; writes there are ignored.
// - Response bits 7:6 select action; code 00 takes no action.
// - Code 01 keeps running for delay 1, then shuts down and retries up to the count if fault persists.
// - Code 10 disables output at once, then retries up to the count.
// - Code 11 holds output off while fault lasts, re-enables once cleared.
// - Delay codes 4-7: 160/320/640/1280 ms and 1596/1932/2268/2604 ms.
// - Retry field gives 0-6 attempts, 7 unlimited; then off until reset.
// - Delay field selects wait before disable and spacing of restarts.
module iof_fault #(
    parameter int CLK_PER_MS = iof_pkg::CLK_PER_MS
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [iof_pkg::VOLT_W-1:0] input_voltage,
    input wire logic [iof_pkg::EXP_W-1:0] exponent_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic output_enable,
    output logic fault_active
);

    iof_pkg::iof_regs_type r;
    iof_pkg::iof_regs_type next_r;
    logic [iof_pkg::VOLT_W-1:0] threshold;
    logic over;
    logic ms_tick;
    logic [1:0] code;
    logic [2:0] retry_lim;
    logic [2:0] dly;
    logic [iof_pkg::MS_W-1:0] d1;
    logic [iof_pkg::MS_W-1:0] d2;
    // Prescaler width, declared ahead of the tick compare that casts to it
    localparam int PRE_W_T = iof_pkg::PRE_W;

    // ------------------------------------------------------------------
    // Threshold compare and field decode
    // ------------------------------------------------------------------
    // Mantissa shifted by exponent, strict compare for the fault
    assign threshold = iof_pkg::VOLT_W'({8'h00, r.mant} << exponent_n);
    assign over = input_voltage > threshold;
    assign ms_tick = r.pre == PRE_W_T'(CLK_PER_MS - 1);
    assign code = r.resp[iof_pkg::RESP_MSB:iof_pkg::RESP_LSB];
    assign retry_lim = r.resp[iof_pkg::RETRY_MSB:iof_pkg::RETRY_LSB];
    assign dly = r.resp[iof_pkg::DELAY_MSB:0];
    assign d1 = iof_pkg::delay1_ms(dly);
    assign d2 = iof_pkg::delay2_ms(dly);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Registers, readback, millisecond timer and response sequencer
    always_comb begin
        next_r = r;
        next_r.fault = over;
        if (reg_wr && reg_addr == iof_pkg::ADDR_LIMIT) begin
            next_r.mant = reg_wdata[iof_pkg::MANT_W-1:0];
        end else if (reg_wr && reg_addr == iof_pkg::ADDR_RESPONSE) begin
            next_r.resp = reg_wdata[7:0];
        end
        if (reg_rd) begin
            if (reg_addr == iof_pkg::ADDR_LIMIT) begin
                next_r.rdata = {2'h0, exponent_n, r.mant};
            end else if (reg_addr == iof_pkg::ADDR_RESPONSE) begin
                next_r.rdata = {8'h00, r.resp};
            end else begin
                next_r.rdata = 16'h0000;
            end
        end
        if (ms_tick) begin
            next_r.pre = '0;
            next_r.ms = r.ms + 12'h001;
        end else begin
            next_r.pre = r.pre + 20'h00001;
        end
        case (r.st)
            iof_pkg::IOF_RUN: begin
                // Timer held at zero so every delay starts on a whole ms
                next_r.pre = '0;
                next_r.ms = '0;
                if (!r.fault) begin
                    next_r.tries = 3'h0;
                end else if (code == iof_pkg::RESP_RIDE) begin
                    next_r.st = iof_pkg::IOF_RIDE;
                end else if (code == iof_pkg::RESP_SHUTDOWN) begin
                    next_r.out_en = 1'b0;
                    next_r.st = iof_pkg::IOF_OFF;
                end else if (code == iof_pkg::RESP_HOLD) begin
                    next_r.out_en = 1'b0;
                    next_r.st = iof_pkg::IOF_HOLD;
                end
            end
            iof_pkg::IOF_RIDE: begin
                if (!r.fault) begin
                    next_r.st = iof_pkg::IOF_RUN;
                end else if (r.ms >= d1) begin
                    next_r.out_en = 1'b0;
                    next_r.pre = '0;
                    next_r.ms = '0;
                    next_r.st = iof_pkg::IOF_OFF;
                end
            end
            iof_pkg::IOF_OFF: begin
                if (retry_lim != iof_pkg::RETRY_INFINITE &&
                    r.tries >= retry_lim) begin
                    next_r.st = iof_pkg::IOF_LOCKED;
                end else if (r.ms >= d2) begin
                    next_r.out_en = 1'b1;
                    next_r.tries = r.tries + 3'h1;
                    next_r.st = iof_pkg::IOF_RUN;
                end
            end
            iof_pkg::IOF_HOLD: begin
                if (!r.fault) begin
                    next_r.out_en = 1'b1;
                    next_r.st = iof_pkg::IOF_RUN;
                end
            end
            default: begin
                next_r.out_en = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset loads constants only
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            r <= '{st: iof_pkg::IOF_RUN, mant: iof_pkg::LIMIT_RESET,
                   resp: iof_pkg::RESPONSE_RESET, rdata: 16'h0000,
                   out_en: 1'b1, fault: 1'b0, pre: '0, ms: '0,
                   tries: 3'h0};
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign output_enable = r.out_en;
    assign fault_active = r.fault;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_fault_follows: assert property (
        ##1 (r.fault == $past(input_voltage > threshold)))
        else $error("fault flag does not follow compare");
    chk_clear_at_limit: assert property (
        (input_voltage <= threshold) |=> !r.fault)
        else $error("fault not cleared at or below limit");
    chk_mant_write: assert property (
        (reg_wr && reg_addr == iof_pkg::ADDR_LIMIT) |=>
        (r.mant == $past(reg_wdata[iof_pkg::MANT_W-1:0])))
        else $error("limit mantissa not written");
    chk_exp_readback: assert property (
        (reg_rd && reg_addr == iof_pkg::ADDR_LIMIT) |=>
        (reg_rdata[15:11] == {2'h0, $past(exponent_n)}))
        else $error("exponent readback wrong");
    chk_ignore_code: assert property (
        (r.st == iof_pkg::IOF_RUN && code == iof_pkg::RESP_IGNORE &&
         r.out_en) |=> r.out_en)
        else $error("output dropped with response 00");
    chk_ride_on: assert property (
        (r.st == iof_pkg::IOF_RIDE) |-> (output_enable && r.ms <= d1))
        else $error("ride through lost output or overran");
    chk_shut_now: assert property (
        (r.st == iof_pkg::IOF_RUN && r.fault &&
         code == iof_pkg::RESP_SHUTDOWN) |=> !output_enable)
        else $error("shutdown not immediate");
    chk_hold_release: assert property (
        (r.st == iof_pkg::IOF_HOLD) |-> (!output_enable ##1
        (output_enable == $past(!r.fault) || !output_enable)))
        else $error("hold response wrong");
    chk_lock_off: assert property (
        (r.st == iof_pkg::IOF_LOCKED) |=>
        (r.st == iof_pkg::IOF_LOCKED && !output_enable))
        else $error("locked state left or output on");
    chk_restart_gap: assert property (
        (r.st == iof_pkg::IOF_OFF && $past(r.st) != iof_pkg::IOF_OFF)
        |-> (r.ms == 12'h000 && !output_enable))
        else $error("restart interval not started at zero");
    // Retry budget spent: the output locks off
    chk_lock_entry: assert property (
        (r.st == iof_pkg::IOF_OFF && retry_lim != iof_pkg::RETRY_INFINITE &&
         r.tries >= retry_lim) |=> (r.st == iof_pkg::IOF_LOCKED))
        else $error("retry limit did not lock output");
    // No restart before the restart interval has run out
    chk_restart_wait: assert property (
        (r.st == iof_pkg::IOF_OFF && r.ms < d2) |=> !output_enable)
        else $error("restart before interval elapsed");
    // Ride through ends in shutdown once delay 1 is reached
    chk_ride_trip: assert property (
        (r.st == iof_pkg::IOF_RIDE && r.fault && r.ms >= d1) |=>
        (r.st == iof_pkg::IOF_OFF && !output_enable))
        else $error("ride through did not shut down");

    // Main scenarios
    cov_ride_trip: cover property (
        r.st == iof_pkg::IOF_RIDE ##1 r.st == iof_pkg::IOF_OFF);
    cov_restart: cover property (
        r.st == iof_pkg::IOF_OFF ##1 r.st == iof_pkg::IOF_RUN);
    cov_lock: cover property (r.st == iof_pkg::IOF_LOCKED);
    cov_shut_trip: cover property (
        r.st == iof_pkg::IOF_RUN ##1 r.st == iof_pkg::IOF_OFF);
    cov_hold_clear: cover property (
        r.st == iof_pkg::IOF_HOLD ##1 r.st == iof_pkg::IOF_RUN);

endmodule : iof_fault

//--- rtl/iof_pkg.sv
/*
 Shared definitions for the input overvoltage fault response block:
 register offsets, field positions, reset values, states and delay tables.
 Assumes a single 50 MHz system clock.
*/
package iof_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_LIMIT = 8'h55;
    localparam logic [7:0] ADDR_RESPONSE = 8'h56;
    localparam logic [10:0] LIMIT_RESET = 11'h7FF;
    localparam logic [7:0] RESPONSE_RESET = 8'h00;
    localparam int MANT_W = 11;
    localparam int EXP_W = 3;
    localparam int VOLT_W = 19;
    localparam int EXP_LSB = 11;
    localparam int RESP_MSB = 7;
    localparam int RESP_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam logic [2:0] RETRY_INFINITE = 3'h7;

    // Response codes
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_RIDE = 2'h1;
    localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
    localparam logic [1:0] RESP_HOLD = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CLK_PER_MS = CLK_HZ / MS_PER_S;
    localparam int PRE_W = 20;
    localparam int MS_W = 12;

    typedef enum logic [2:0] {
        IOF_RUN, IOF_RIDE, IOF_OFF, IOF_HOLD, IOF_LOCKED
    } iof_state_type;

    typedef struct packed {
        iof_state_type st;
        logic [MANT_W-1:0] mant;
        logic [7:0] resp;
        logic [15:0] rdata;
        logic out_en;
        logic fault;
        logic [PRE_W-1:0] pre;
        logic [MS_W-1:0] ms;
        logic [2:0] tries;
    } iof_regs_type;

    // First delay in ms per delay code
    function automatic logic [MS_W-1:0] delay1_ms(input logic [2:0] code);
        case (code)
            3'h0: delay1_ms = 12'd10;
            3'h1: delay1_ms = 12'd20;
            3'h2: delay1_ms = 12'd40;
            3'h3: delay1_ms = 12'd80;
            3'h4: delay1_ms = 12'd160;
            3'h5: delay1_ms = 12'd320;
            3'h6: delay1_ms = 12'd640;
            default: delay1_ms = 12'd1280;
        endcase
    endfunction : delay1_ms

    // Restart interval in ms per delay code
    function automatic logic [MS_W-1:0] delay2_ms(input logic [2:0] code);
        case (code)
            3'h0: delay2_ms = 12'd252;
            3'h1: delay2_ms = 12'd558;
            3'h2: delay2_ms = 12'd924;
            3'h3: delay2_ms = 12'd1260;
            3'h4: delay2_ms = 12'd1596;
            3'h5: delay2_ms = 12'd1932;
            3'h6: delay2_ms = 12'd2268;
            default: delay2_ms = 12'd2604;
        endcase
    endfunction : delay2_ms

endpackage : iof_pkg

//--- tb/iof_host.sv
/*
 Host model driving the register strobes of iof_fault.
 Assumes clk_sys from the bench; tasks are called hierarchically.
*/
module iof_host (
    input wire logic clk_sys,
    input wire logic [15:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end

    // One-cycle write strobe; released lines show inverted values
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // One-cycle read strobe, data taken once registered
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(posedge clk_sys);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : iof_host

//--- tb/testbench.sv
/*
 Self-checking bench for iof_fault with a fast ms tick.
 Assumes the host model iof_host and package iof_pkg.
*/
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CPM = 4;
    logic clk_sys, rst_b, reg_wr, reg_rd, output_enable, fault_active;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rv;
    logic [iof_pkg::VOLT_W-1:0] input_voltage;
    logic [iof_pkg::EXP_W-1:0] exponent_n;
    int n_mismatch, cmp_count;

    iof_fault #(.CLK_PER_MS(CPM)) iof_fault_inst (.clk_sys(clk_sys),
        .rst_b(rst_b), .input_voltage(input_voltage),
        .exponent_n(exponent_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .output_enable(output_enable), .fault_active(fault_active));
    iof_host iof_host_inst (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic chk_word(input string s, input logic [15:0] e);
        cmp_count++;
        if (rv !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", s, e, rv);
        end
    endtask : chk_word
    task automatic chk_bit(input string s, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", s, e, g);
        end
    endtask : chk_bit
    // Reset for 20 cycles, then set limit 0x064 and the response
    task automatic start(input logic [7:0] resp);
        input_voltage = 19'h0;
        rst_b = 1'b0;
        cyc(20);
        rst_b = 1'b1;
        cyc(1);
        iof_host_inst.wr(iof_pkg::ADDR_LIMIT, 16'hF864);
        iof_host_inst.wr(iof_pkg::ADDR_RESPONSE, {8'h00, resp});
    endtask : start
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // Watchdog
    initial begin
        #400_000;
        n_mismatch++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    // Threshold is 0x064 shifted by 3, that is 800
    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        exponent_n = 3'h3;
        input_voltage = 19'h0;
        rst_b = 1'b0;
        cyc(20);
        rst_b = 1'b1;
        cyc(1);
        iof_host_inst.rd(iof_pkg::ADDR_LIMIT, rv);
        chk_word("limit reset", 16'h1FFF);
        iof_host_inst.rd(8'h57, rv);
        chk_word("unmapped read", 16'h0000);
        start(8'h00);
        iof_host_inst.rd(iof_pkg::ADDR_LIMIT, rv);
        chk_word("limit readback", 16'h1864);
        input_voltage = 19'd800;
        cyc(3);
        chk_bit("fault at limit", 1'b0, fault_active);
        input_voltage = 19'd801;
        cyc(3);
        chk_bit("fault above", 1'b1, fault_active);
        cyc(50);
        chk_bit("ignore code", 1'b1, output_enable);
        exponent_n = 3'h0;
        iof_host_inst.rd(iof_pkg::ADDR_LIMIT, rv);
        chk_word("limit with n 0", 16'h0064);
        input_voltage = 19'd100;
        cyc(3);
        chk_bit("fault at n 0 limit", 1'b0, fault_active);
        input_voltage = 19'd101;
        cyc(3);
        chk_bit("fault above n 0", 1'b1, fault_active);
        exponent_n = 3'h3;
        $display("test threshold done");
        start(8'hC0);
        input_voltage = 19'd801;
        cyc(100);
        chk_bit("hold off", 1'b0, output_enable);
        input_voltage = 19'd800;
        cyc(4);
        chk_bit("hold on", 1'b1, output_enable);
        $display("test hold done");
        start(8'h88);
        iof_host_inst.rd(iof_pkg::ADDR_RESPONSE, rv);
        chk_word("response", 16'h0088);
        input_voltage = 19'd801;
        cyc(4);
        chk_bit("shutdown", 1'b0, output_enable);
        cyc(900);
        chk_bit("before restart", 1'b0, output_enable);
        for (int i = 0; i < 200 && output_enable !== 1'b1; i++) cyc(1);
        chk_bit("restart", 1'b1, output_enable);
        cyc(4);
        input_voltage = 19'd0;
        cyc(1200);
        chk_bit("locked", 1'b0, output_enable);
        $display("test shutdown done");
        // Unlimited retries: more restarts than any finite count allows
        start(8'hB8);
        input_voltage = 19'd801;
        for (int k = 0; k < 8; k++) begin
            cyc(4);
            chk_bit("retry off", 1'b0, output_enable);
            for (int i = 0; i < 1100 && output_enable !== 1'b1; i++) cyc(1);
            chk_bit("unlimited retry", 1'b1, output_enable);
        end
        $display("test unlimited done");
        start(8'h40);
        input_voltage = 19'd801;
        cyc(30);
        chk_bit("ride", 1'b1, output_enable);
        cyc(20);
        chk_bit("ride end", 1'b0, output_enable);
        cyc(1100);
        chk_bit("no retry", 1'b0, output_enable);
        start(8'h44);
        input_voltage = 19'd801;
        cyc(600);
        chk_bit("long ride", 1'b1, output_enable);
        cyc(80);
        chk_bit("long ride end", 1'b0, output_enable);
        $display("test ride done");
        print_verdict();
    end
endmodule : testbench
